/* File: lbbe_alu.sv */
// Arithmetic unit: add with carry, AND and single bit clear
`timescale 1ns/1ps
module lbbe_alu (
    lbbe_alu_if.unit alu
);
    logic [8:0] sum;
    logic [4:0] half;

    always_comb begin
        sum = 9'({1'b0, alu.opa} + {1'b0, alu.opb} + {8'h00, alu.cin});
        half = 5'({1'b0, alu.opa[3:0]} + {1'b0, alu.opb[3:0]} + {4'h0, alu.cin});
        alu.result = 8'h00;
        alu.flags = 5'h00;
        unique case (alu.op)
            lbbe_pkg::OP_ADDC: begin
                alu.result = sum[7:0];
                alu.flags[lbbe_pkg::FLG_CARRY] = sum[8];
                alu.flags[lbbe_pkg::FLG_HALF] = half[4];
                // Signed overflow: like-signed operands giving an opposite-signed sum
                alu.flags[lbbe_pkg::FLG_OVFL] = (alu.opa[7] == alu.opb[7]) &&
                                                (sum[7] != alu.opa[7]);
            end
            lbbe_pkg::OP_ANDL, lbbe_pkg::OP_ANDF: begin
                alu.result = alu.opa & alu.opb;
            end
            lbbe_pkg::OP_CLRB: begin
                alu.result = alu.opb & ~(8'h01 << alu.bit_sel);
            end
            default: begin
                alu.result = alu.opb;
            end
        endcase
        alu.flags[lbbe_pkg::FLG_ZERO] = (alu.result == 8'h00);
        alu.flags[lbbe_pkg::FLG_NEG] = alu.result[7];
    end
endmodule

/* File: lbbe_alu_if.sv */
// Operand and result bundle between the sequencer and the arithmetic unit
`timescale 1ns/1ps
interface lbbe_alu_if;
    lbbe_pkg::lbbe_op_e op;
    logic [7:0] opa;
    logic [7:0] opb;
    logic cin;
    logic [2:0] bit_sel;
    logic [7:0] result;
    logic [4:0] flags;

    modport seq (output op, opa, opb, cin, bit_sel, input result, flags);
    modport unit (input op, opa, opb, cin, bit_sel, output result, flags);
endinterface

/* File: lbbe_dmem_model.sv */
// Behavioural banked data memory facing the execution slice
`timescale 1ns/1ps
module lbbe_dmem_model (
    // Clock
    input wire logic core_clk,
    // Data port
    input wire logic [11:0] mem_addr,
    input wire logic mem_rd_en,
    input wire logic mem_wr_en,
    input wire logic [7:0] mem_wr_data,
    output logic [7:0] mem_rd_data
);
    logic [7:0] mem [0:4095];
    logic [7:0] last_r = 8'h00;

    // Outside a read the port shows the inverse of the last read, so stale data never passes
    assign mem_rd_data = mem_rd_en ? mem[mem_addr] : ~last_r;

    always @(posedge core_clk) begin
        if (mem_rd_en)
            last_r <= mem[mem_addr];
        if (mem_wr_en)
            mem[mem_addr] <= mem_wr_data;
    end
endmodule

/* File: lbbe_exec.sv */
// Four-phase execution of add-with-carry, AND, branch-on-carry and bit clear
// Behaviour
// - Literal AND: accumulator AND literal into accumulator
// - AND updates only negative and zero flags
// - File AND: accumulator AND register to destination
// - Destination bit 0 accumulator, 1 file register
// - Access bit 0 access bank, 1 bank register
// - Literal AND takes one four-phase cycle
// - Branch when carry set; flags unchanged
// - Target is incremented PC plus doubled offset
// - Taken branch: two cycles, second is idle
// - Untaken branch: one cycle, no write
// - Clear one register bit, read-modify-write, flags kept
// - Add with carry updates all five flags
`timescale 1ns/1ps
module lbbe_exec #(
    parameter int PC_W = 21
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Instruction fetch side
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [PC_W-1:0] pc_in,
    output logic instr_ready,
    output logic pc_load,
    output logic [PC_W-1:0] pc_target,
    // Data memory side
    input wire logic [lbbe_pkg::BANK_W-1:0] bank_select_reg,
    input wire logic [7:0] mem_rd_data,
    output logic [lbbe_pkg::DADDR_W-1:0] mem_addr,
    output logic mem_rd_en,
    output logic mem_wr_en,
    output logic [7:0] mem_wr_data,
    // Core state
    output logic [7:0] acc_out,
    output logic [lbbe_pkg::FLAG_W-1:0] status_out
);
    typedef struct packed {
        lbbe_pkg::lbbe_phase_e phase;
        logic flush;
        lbbe_pkg::lbbe_op_e op;
        logic [15:0] word;
        logic [PC_W-1:0] pc_base;
        logic [7:0] operand;
        logic [7:0] acc;
        logic [lbbe_pkg::FLAG_W-1:0] status;
        logic [lbbe_pkg::FLAG_W-1:0] flags_new;
        logic [lbbe_pkg::DADDR_W-1:0] addr;
        logic rd_en;
        logic wr_en;
        logic [7:0] wr_data;
        logic acc_wr;
        logic pc_load;
        logic [PC_W-1:0] pc_target;
    } lbbe_state_s;

    lbbe_state_s st_r;
    lbbe_state_s st_nxt;
    lbbe_alu_if alu ();
    logic take;
    logic to_file;
    logic to_acc;
    lbbe_pkg::lbbe_op_e dec_op;
    logic [lbbe_pkg::DADDR_W-1:0] dec_addr;

    lbbe_alu u_alu (
        .alu(alu)
    );

    function automatic lbbe_pkg::lbbe_op_e decode(input logic [15:0] w);
        lbbe_pkg::lbbe_op_e op;
        op = lbbe_pkg::OP_NONE;
        if (w[15:8] == lbbe_pkg::OPC_AND_LIT) begin
            op = lbbe_pkg::OP_ANDL;
        end else if (w[15:10] == lbbe_pkg::OPC_AND_FILE) begin
            op = lbbe_pkg::OP_ANDF;
        end else if (w[15:10] == lbbe_pkg::OPC_ADD_CARRY) begin
            op = lbbe_pkg::OP_ADDC;
        end else if (w[15:8] == lbbe_pkg::OPC_BR_CARRY) begin
            op = lbbe_pkg::OP_BRC;
        end else if (w[15:12] == lbbe_pkg::OPC_CLR_BIT) begin
            op = lbbe_pkg::OP_CLRB;
        end
        return op;
    endfunction

    // A new word is accepted only at the first phase, and never in a flushed cycle
    assign take = instr_valid && (st_r.phase == lbbe_pkg::PH_Q1) && !st_r.flush;
    assign instr_ready = (st_r.phase == lbbe_pkg::PH_Q1) && !st_r.flush;
    assign dec_op = decode(instr_word);
    assign dec_addr = instr_word[lbbe_pkg::ACCESS_POS] ?
        {bank_select_reg, instr_word[7:0]} :
        {(instr_word[7] ? lbbe_pkg::ACCESS_HI_BANK : lbbe_pkg::ACCESS_LO_BANK),
         instr_word[7:0]};

    // Add and file AND results go to the file when the destination bit is set; bit clear always writes the file
    assign to_file = (((st_r.op == lbbe_pkg::OP_ADDC) || (st_r.op == lbbe_pkg::OP_ANDF)) &&
                      st_r.word[lbbe_pkg::DEST_POS]) ||
                     (st_r.op == lbbe_pkg::OP_CLRB);
    assign to_acc = (st_r.op == lbbe_pkg::OP_ANDL) ||
                    (((st_r.op == lbbe_pkg::OP_ADDC) || (st_r.op == lbbe_pkg::OP_ANDF)) &&
                     !st_r.word[lbbe_pkg::DEST_POS]);

    assign alu.op = st_r.op;
    assign alu.opa = st_r.acc;
    assign alu.opb = st_r.operand;
    assign alu.cin = st_r.status[lbbe_pkg::FLG_CARRY];
    assign alu.bit_sel = st_r.word[lbbe_pkg::BITSEL_LSB +: 3];

    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_en = 1'b0;
        st_nxt.wr_en = 1'b0;
        st_nxt.acc_wr = 1'b0;
        st_nxt.pc_load = 1'b0;
        unique case (st_r.phase)
            lbbe_pkg::PH_Q1: begin
                // Decode
                st_nxt.phase = lbbe_pkg::PH_Q2;
                st_nxt.op = lbbe_pkg::OP_NONE;
                if (take) begin
                    st_nxt.word = instr_word;
                    st_nxt.op = dec_op;
                    st_nxt.pc_base = pc_in;
                    st_nxt.addr = dec_addr;
                    st_nxt.rd_en = (dec_op == lbbe_pkg::OP_ADDC) ||
                                   (dec_op == lbbe_pkg::OP_ANDF) ||
                                   (dec_op == lbbe_pkg::OP_CLRB);
                end
            end
            lbbe_pkg::PH_Q2: begin
                // Read literal or register
                st_nxt.phase = lbbe_pkg::PH_Q3;
                st_nxt.operand = st_r.rd_en ? mem_rd_data : st_r.word[7:0];
            end
            lbbe_pkg::PH_Q3: begin
                // Process; the write strobes are registered so they stand through Q4
                st_nxt.phase = lbbe_pkg::PH_Q4;
                st_nxt.flags_new = alu.flags;
                st_nxt.wr_data = alu.result;
                st_nxt.wr_en = to_file;
                st_nxt.acc_wr = to_acc;
                if ((st_r.op == lbbe_pkg::OP_BRC) &&
                    st_r.status[lbbe_pkg::FLG_CARRY]) begin
                    st_nxt.pc_load = 1'b1;
                    st_nxt.pc_target = st_r.pc_base +
                        {{(PC_W-9){st_r.word[7]}}, st_r.word[7:0], 1'b0};
                end
            end
            lbbe_pkg::PH_Q4: begin
                // Write destination
                st_nxt.phase = lbbe_pkg::PH_Q1;
                if (st_r.acc_wr) begin
                    st_nxt.acc = st_r.wr_data;
                end
                if (st_r.op == lbbe_pkg::OP_ADDC) begin
                    st_nxt.status = st_r.flags_new;
                end else if ((st_r.op == lbbe_pkg::OP_ANDL) ||
                             (st_r.op == lbbe_pkg::OP_ANDF)) begin
                    st_nxt.status = (st_r.status & ~lbbe_pkg::AND_FLAG_MASK) |
                                    (st_r.flags_new & lbbe_pkg::AND_FLAG_MASK);
                end
                // A taken branch idles for the whole next instruction cycle
                st_nxt.flush = st_r.pc_load;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '{phase: lbbe_pkg::PH_Q1, op: lbbe_pkg::OP_NONE,
                      acc: lbbe_pkg::ACC_RESET, status: lbbe_pkg::STATUS_RESET,
                      default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pc_load = st_r.pc_load;
    assign pc_target = st_r.pc_target;
    assign mem_addr = st_r.addr;
    assign mem_rd_en = st_r.rd_en;
    assign mem_wr_en = st_r.wr_en;
    assign mem_wr_data = st_r.wr_data;
    assign acc_out = st_r.acc;
    assign status_out = st_r.status;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    logic carry_now;
    assign carry_now = status_out[lbbe_pkg::FLG_CARRY];

    a_and_lit_acc: assert property (
        take && (dec_op == lbbe_pkg::OP_ANDL) |->
        ##4 acc_out == ($past(acc_out, 4) & $past(instr_word[7:0], 4)))
        else $error("literal AND result wrong");

    a_and_flags_kept: assert property (
        take && ((dec_op == lbbe_pkg::OP_ANDL) || (dec_op == lbbe_pkg::OP_ANDF)) |->
        ##4 (status_out & ~lbbe_pkg::AND_FLAG_MASK) ==
            ($past(status_out, 4) & ~lbbe_pkg::AND_FLAG_MASK))
        else $error("AND changed a protected flag");

    a_and_file_write: assert property (
        take && (dec_op == lbbe_pkg::OP_ANDF) && instr_word[lbbe_pkg::DEST_POS] |->
        ##3 mem_wr_en && (mem_wr_data == ($past(acc_out, 3) & $past(mem_rd_data, 2))))
        else $error("file AND write wrong");

    a_dest_acc_only: assert property (
        take && (dec_op == lbbe_pkg::OP_ANDF) && !instr_word[lbbe_pkg::DEST_POS] |->
        ##3 !mem_wr_en ##1 acc_out == ($past(acc_out, 4) & $past(mem_rd_data, 3)))
        else $error("accumulator destination wrong");

    a_bank_select: assert property (
        take && (dec_op != lbbe_pkg::OP_NONE) && (dec_op != lbbe_pkg::OP_BRC) &&
        (dec_op != lbbe_pkg::OP_ANDL) |->
        ##1 mem_rd_en && mem_addr[7:0] == $past(instr_word[7:0]) &&
            mem_addr[11:8] == ($past(instr_word[lbbe_pkg::ACCESS_POS]) ?
                $past(bank_select_reg) :
                ($past(instr_word[7]) ? lbbe_pkg::ACCESS_HI_BANK :
                 lbbe_pkg::ACCESS_LO_BANK)))
        else $error("data bank selection wrong");

    a_lit_one_cycle: assert property (
        take && (dec_op == lbbe_pkg::OP_ANDL) |-> ##1 !instr_ready [*3] ##1 instr_ready)
        else $error("literal AND not one cycle");

    a_branch_flags: assert property (
        take && (dec_op == lbbe_pkg::OP_BRC) |->
        ##3 (pc_load == $past(carry_now, 3)) ##1 status_out == $past(status_out, 4))
        else $error("branch condition or flags wrong");

    a_branch_target: assert property (
        take && (dec_op == lbbe_pkg::OP_BRC) && carry_now |->
        ##3 pc_target == $past(pc_in, 3) +
            {{(PC_W-9){$past(instr_word[7], 3)}}, $past(instr_word[7:0], 3), 1'b0})
        else $error("branch target wrong");

    a_taken_two_cycles: assert property (
        take && (dec_op == lbbe_pkg::OP_BRC) && carry_now |->
        ##4 (!instr_ready && !mem_wr_en && !pc_load) [*4] ##1 instr_ready)
        else $error("taken branch timing wrong");

    a_untaken_one: assert property (
        take && (dec_op == lbbe_pkg::OP_BRC) && !carry_now |->
        ##3 !pc_load && !mem_wr_en ##1 instr_ready)
        else $error("untaken branch timing wrong");

    a_clear_bit_rmw: assert property (
        take && (dec_op == lbbe_pkg::OP_CLRB) |->
        ##3 mem_wr_en && (mem_wr_data == ($past(mem_rd_data, 2) &
            ~(8'h01 << $past(instr_word[lbbe_pkg::BITSEL_LSB +: 3], 3))))
        ##1 status_out == $past(status_out, 4))
        else $error("bit clear wrong");

    a_add_carry_sum: assert property (
        take && (dec_op == lbbe_pkg::OP_ADDC) && !instr_word[lbbe_pkg::DEST_POS] |->
        ##4 acc_out == 8'($past(acc_out, 4) + $past(mem_rd_data, 3) +
                          {7'h00, $past(carry_now, 4)}))
        else $error("add with carry wrong");

    a_add_flags: assert property (
        take && (dec_op == lbbe_pkg::OP_ADDC) && !instr_word[lbbe_pkg::DEST_POS] |->
        ##4 (status_out[lbbe_pkg::FLG_ZERO] == (acc_out == 8'h00)) &&
            (status_out[lbbe_pkg::FLG_NEG] == acc_out[7]) &&
            (status_out[lbbe_pkg::FLG_CARRY] == (({1'b0, $past(acc_out, 4)} +
                {1'b0, $past(mem_rd_data, 3)} + {8'h00, $past(carry_now, 4)}) > 9'h0FF)) &&
            (status_out[lbbe_pkg::FLG_OVFL] == (($past(acc_out[7], 4) ==
                $past(mem_rd_data[7], 3)) && (acc_out[7] != $past(acc_out[7], 4)))))
        else $error("add with carry flags wrong");

    a_add_file_write: assert property (
        take && (dec_op == lbbe_pkg::OP_ADDC) && instr_word[lbbe_pkg::DEST_POS] |->
        ##3 mem_wr_en && (mem_wr_data == 8'($past(acc_out, 3) + $past(mem_rd_data, 2) +
                                          {7'h00, $past(carry_now, 3)}))
        ##1 acc_out == $past(acc_out, 4))
        else $error("add with carry file write wrong");

    a_rd_one_cycle: assert property (
        mem_rd_en |=> !mem_rd_en)
        else $error("read strobe longer than one cycle");

    a_wr_one_cycle: assert property (
        mem_wr_en |=> !mem_wr_en)
        else $error("write strobe longer than one cycle");

    // The idle cycle after a load must hold off the next word at once
    a_load_one_cycle: assert property (
        pc_load |=> !pc_load && !instr_ready)
        else $error("program counter load not a single pulse");

    a_clear_acc_kept: assert property (
        take && (dec_op == lbbe_pkg::OP_CLRB) |-> ##4 acc_out == $past(acc_out, 4))
        else $error("bit clear touched the accumulator");

    c_taken: cover property (take && (dec_op == lbbe_pkg::OP_BRC) && carry_now);
    c_untaken: cover property (take && (dec_op == lbbe_pkg::OP_BRC) && !carry_now);
    c_file_and: cover property (take && (dec_op == lbbe_pkg::OP_ANDF) &&
                                instr_word[lbbe_pkg::DEST_POS]);
    c_clear: cover property (take && (dec_op == lbbe_pkg::OP_CLRB));
    c_add_file: cover property (take && (dec_op == lbbe_pkg::OP_ADDC) &&
                                instr_word[lbbe_pkg::DEST_POS]);
endmodule

/* File: lbbe_exec_bench.sv */
// Self-checking bench for the execution slice
`timescale 1ns/1ps
module lbbe_exec_bench;
    localparam int PC_W = 21;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [PC_W-1:0] pc_in = '0;
    logic [3:0] bank_select_reg = 4'h0;
    wire logic instr_ready;
    wire logic pc_load;
    wire logic mem_rd_en;
    wire logic mem_wr_en;
    wire logic [PC_W-1:0] pc_target;
    wire logic [11:0] mem_addr;
    wire logic [7:0] mem_rd_data;
    wire logic [7:0] mem_wr_data;
    wire logic [7:0] acc_out;
    wire logic [4:0] status_out;
    int mismatches = 0;
    int checks_done = 0;
    int loads = 0;
    int cyc = 0;
    logic [PC_W-1:0] last_tgt = '0;

    lbbe_exec #(.PC_W(PC_W)) i_lbbe_exec (.core_clk(core_clk), .resetn(resetn),
        .instr_valid(instr_valid), .instr_word(instr_word), .pc_in(pc_in),
        .instr_ready(instr_ready), .pc_load(pc_load), .pc_target(pc_target),
        .bank_select_reg(bank_select_reg), .mem_rd_data(mem_rd_data), .mem_addr(mem_addr),
        .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data),
        .acc_out(acc_out), .status_out(status_out));

    lbbe_dmem_model i_lbbe_dmem_model (.core_clk(core_clk), .mem_addr(mem_addr),
        .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data),
        .mem_rd_data(mem_rd_data));

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (pc_load === 1'b1) begin
            loads++;
            last_tgt = pc_target;
        end
    end

    task automatic end_of_test();
        if (mismatches == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Offer one word at a Q1 and count cycles until the slice is ready for the next word
    task automatic run(input logic [15:0] w, input logic [PC_W-1:0] pc, input logic [3:0] bank);
        int n;
        n = 0;
        while (instr_ready !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        instr_valid = 1'b1;
        instr_word = w;
        pc_in = pc;
        bank_select_reg = bank;
        @(negedge core_clk);
        instr_valid = 1'b0;
        cyc = 1;
        while (instr_ready !== 1'b1 && cyc < 20) begin
            @(negedge core_clk);
            cyc++;
        end
        chk({31'h0, instr_ready}, 32'h1);
    endtask

    task automatic t_add_load();
        run(16'h2005, '0, 4'h0);
        chk(acc_out, 32'hA3);
        run(16'h2006, '0, 4'h0);
        chk(acc_out, 32'hA2);
        chk(status_out, 32'h13);
    endtask

    task automatic t_and_lit();
        run(16'h0B5F, '0, 4'h0);
        chk(acc_out, 32'h02);
        chk(status_out, 32'h03);
        chk(cyc, 4);
        run(16'h0B00, '0, 4'h0);
        chk(status_out, 32'h07);
    endtask

    task automatic t_and_file();
        run(16'h2005, '0, 4'h0);
        run(16'h1720, '0, 4'h2);
        chk(i_lbbe_dmem_model.mem[12'h220], 32'h84);
        chk(acc_out, 32'hA4);
        chk(status_out, 32'h10);
        run(16'h1485, '0, 4'h2);
        chk(acc_out, 32'h04);
        chk(status_out, 32'h00);
    endtask

    task automatic t_branch_skip();
        loads = 0;
        run(16'hE2FE, 21'h100, 4'h0);
        chk(loads, 0);
        chk(cyc, 4);
    endtask

    task automatic br(input logic [15:0] w, input logic [PC_W-1:0] pc, input logic [31:0] exp);
        loads = 0;
        run(w, pc, 4'h0);
        chk(loads, 1);
        chk(last_tgt, exp);
        chk(cyc, 8);
        chk(status_out, 32'h03);
    endtask

    task automatic t_branch_taken();
        run(16'h2006, '0, 4'h0);
        chk(status_out, 32'h03);
        br(16'hE2FE, 21'h100, 32'h0FC);
        br(16'hE27F, 21'h1000, 32'h10FE);
        br(16'hE280, 21'h200, 32'h100);
    endtask

    task automatic t_clear();
        run(16'h9F30, '0, 4'h3);
        chk(i_lbbe_dmem_model.mem[12'h330], 32'h47);
        for (int b = 0; b < 8; b++) begin
            run({4'h9, b[2:0], 1'b0, 8'h10}, '0, 4'h3);
            chk(i_lbbe_dmem_model.mem[12'h010], (32'hFF << (b + 1)) & 32'hFF);
        end
        chk(status_out, 32'h03);
        chk(acc_out, 32'h03);
    endtask

    // Add with carry into a banked file register, signed overflow on the way
    task automatic t_add_file();
        run(16'h2305, '0, 4'h4);
        chk(i_lbbe_dmem_model.mem[12'h405], 32'h80);
        chk(acc_out, 32'h03);
        chk(status_out, 32'h1A);
    endtask

    initial begin
        i_lbbe_dmem_model.mem[12'h005] = 8'hA3;
        i_lbbe_dmem_model.mem[12'h006] = 8'hFF;
        i_lbbe_dmem_model.mem[12'h220] = 8'hC7;
        i_lbbe_dmem_model.mem[12'hF85] = 8'h0F;
        i_lbbe_dmem_model.mem[12'h330] = 8'hC7;
        i_lbbe_dmem_model.mem[12'h010] = 8'hFF;
        i_lbbe_dmem_model.mem[12'h405] = 8'h7C;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        t_add_load();
        t_and_lit();
        t_and_file();
        t_branch_skip();
        t_branch_taken();
        t_clear();
        t_add_file();
        end_of_test();
    end

    // The 22 instructions of at most 8 cycles fit well inside this span
    initial begin
        #20000;
        mismatches++;
        end_of_test();
    end
endmodule

/* File: lbbe_pkg.sv */
// Shared constants and types for the logic, branch and bit-clear execution slice
package lbbe_pkg;

    // Opcode patterns, compared against the top bits of the instruction word
    localparam logic [7:0] OPC_AND_LIT = 8'h0B;
    localparam logic [5:0] OPC_AND_FILE = 6'h05;
    localparam logic [5:0] OPC_ADD_CARRY = 6'h08;
    localparam logic [7:0] OPC_BR_CARRY = 8'hE2;
    localparam logic [3:0] OPC_CLR_BIT = 4'h9;

    // Instruction word field positions
    localparam int DEST_POS = 9;
    localparam int ACCESS_POS = 8;
    localparam int BITSEL_LSB = 9;

    // Status flag positions
    localparam int FLG_CARRY = 0;
    localparam int FLG_HALF = 1;
    localparam int FLG_ZERO = 2;
    localparam int FLG_OVFL = 3;
    localparam int FLG_NEG = 4;
    localparam int FLAG_W = 5;

    // Flags touched by the AND instructions
    localparam logic [4:0] AND_FLAG_MASK = 5'h14;

    // Reset values
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] STATUS_RESET = 5'h00;

    // Access bank: low half of the file range maps to bank 0, high half to the top bank
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

    // Data address and bank widths
    localparam int BANK_W = 4;
    localparam int DADDR_W = 12;

    // Instruction phases within one instruction cycle
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } lbbe_phase_e;

    // Decoded operations
    typedef enum logic [5:0] {
        OP_NONE = 6'b000001,
        OP_ADDC = 6'b000010,
        OP_ANDL = 6'b000100,
        OP_ANDF = 6'b001000,
        OP_BRC = 6'b010000,
        OP_CLRB = 6'b100000
    } lbbe_op_e;

endpackage
